// ===== lhi_host_port.sv
// How it works
// - Serial, 4-bit or 8-bit host bus
// - Two 8-bit host registers only
// - Instruction register cannot be read back
// - Data writes copied into addressed memory
// - Address set prefetches byte into holder
// - Each data read refills from next address
// - Select/direction decode: instr, status, data
// - Busy blocks acceptance of next instruction
// - Address set loads counter and target
// - Counter steps by one after access
// - Five lines of twelve, stride sixteen
// - One or two lines, same map
// - Selectable display start line
// - Reset pin initialises everything
// - Strap reverses segment numbering
`timescale 1ns/1ps
`default_nettype none
module lhi_host_port #(
  parameter int EXEC_CYCLES  = lhi_pkg::EXEC_CYC,
  parameter int CLEAR_CYCLES = lhi_pkg::CLEAR_CYC,
  parameter int BUF_DEPTH    = 2
) (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       interface_select_hi,
  input  wire logic       interface_select_lo,
  input  wire logic       register_select_line,
  input  wire logic       read_write_line,
  input  wire logic       enable_strobe,
  input  wire logic [7:0] bus_data_in,
  output logic      [7:0] bus_data_out,
  output logic            bus_data_oe,
  input  wire logic       serial_cs_n,
  input  wire logic       serial_clk,
  input  wire logic       serial_data,
  input  wire logic       segment_order_strap,
  input  wire logic       scan_row,
  input  wire logic [3:0] scan_col,
  output logic      [7:0] scan_char,
  output logic            seg_reversed,
  output logic            two_lines,
  output logic      [2:0] start_line,
  output logic            busy_flag
);
  import lhi_pkg::*;

  if (EXEC_CYCLES < 1 || CLEAR_CYCLES < 1 || CLEAR_CYCLES >= 2**BUSY_CNT_W
      || EXEC_CYCLES >= 2**BUSY_CNT_W) begin : g_chk
    $error("lhi_host_port: busy cycle counts out of range");
  end

  localparam logic [BUSY_CNT_W-1:0] EXEC_LAST  = BUSY_CNT_W'(EXEC_CYCLES - 1);
  localparam logic [BUSY_CNT_W-1:0] CLEAR_LAST = BUSY_CNT_W'(CLEAR_CYCLES - 1);

  typedef struct packed {
    logic [DISP_CELLS-1:0][7:0]  disp;
    logic [GLYPH_WORDS-1:0][4:0] glyph;
    logic [ICON_WORDS-1:0][4:0]  icon;
    logic [ANN_WORDS-1:0][4:0]   ann;
    lhi_tgt_t                    tgt;
    logic [6:0]                  ac;
    logic [7:0]                  dr;
    logic                        dir_up;
    logic                        two_lines;
    logic [2:0]                  start_line;
    logic                        seg_reversed;
    logic                        busy;
    logic [BUSY_CNT_W-1:0]       busy_cnt;
    logic                        busy_flag;
    logic [7:0]                  bus_data_out;
    logic                        bus_data_oe;
    logic [7:0]                  scan_char;
  } lhi_state_t;

  lhi_state_t st;
  lhi_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Front end and command buffer

  lhi_word_if wr_a ();
  lhi_word_if wr_b ();
  logic       rd_done;
  logic       low_phase;
  logic [1:0] mode;

  assign mode = {interface_select_hi, interface_select_lo};

  lhi_front u_front (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .ce        (ce),
    .mode      (mode),
    .rs        (register_select_line),
    .rw        (read_write_line),
    .en        (enable_strobe),
    .db_in     (bus_data_in),
    .ser_cs_n  (serial_cs_n),
    .ser_clk   (serial_clk),
    .ser_data  (serial_data),
    .wr        (wr_a.src),
    .rd_done   (rd_done),
    .low_phase (low_phase)
  );

  lhi_buf #(
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .sys_clk (sys_clk),
    .srst    (srst),
    .ce      (ce),
    .in_w    (wr_a.snk),
    .out_w   (wr_b.src)
  );

  // Core takes a word only when idle; pending words wait in the buffer
  assign wr_b.ready = ce & ~st.busy;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // {valid, index} of a display address; columns 12..15 of a line are holes
  function automatic logic [6:0] disp_idx(input logic [6:0] a);
    logic [2:0] ln;
    logic [3:0] col;
    ln  = a[6:4];
    col = a[3:0];
    disp_idx = {(ln <= LAST_LINE) && (col <= LAST_COL),
                6'(ln) * 6'd12 + 6'(col)};
  endfunction : disp_idx

  function automatic logic [7:0] mem_rd(input lhi_state_t s, input lhi_tgt_t t,
                                        input logic [6:0] a);
    logic [6:0] di;
    di     = disp_idx(a);
    mem_rd = 8'h00;
    unique case (t)
      TGT_DISP:  mem_rd = di[6] ? s.disp[di[5:0]] : 8'h00;
      TGT_GLYPH: mem_rd = {3'h0, s.glyph[a[4:0]]};
      TGT_ICON:  mem_rd = {3'h0, s.icon[a[2:0]]};
      TGT_ANN:   mem_rd = {3'h0, s.ann[a[0]]};
    endcase
  endfunction : mem_rd

  function automatic logic [6:0] step(input logic [6:0] a, input logic up);
    step = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
  endfunction : step

  ////////////////////////////////////////////////////////////////////////////
  // Core engine

  logic [7:0] op;
  logic [6:0] wi;
  logic [6:0] si;
  logic [2:0] sl;
  logic [3:0] sc;
  logic [7:0] status;
  logic [7:0] rd_byte;

  always_comb begin
    next_st = st;
    op      = wr_b.word.data;
    wi      = disp_idx(st.ac);
    si      = 7'h00;
    sl      = 3'h0;
    sc      = 4'h0;
    status  = 8'h00;
    rd_byte = 8'h00;

    // Strap is static, so sampling it every cycle is enough
    next_st.seg_reversed = segment_order_strap;

    if (st.busy) begin
      if (st.busy_cnt == '0) begin
        next_st.busy = 1'b0;
      end else begin
        next_st.busy_cnt = st.busy_cnt - 1'b1;
      end
    end

    if (rd_done) begin
      next_st.ac = step(st.ac, st.dir_up);
      next_st.dr = mem_rd(st, st.tgt, step(st.ac, st.dir_up));
    end

    if (wr_b.valid && wr_b.ready) begin
      next_st.busy     = 1'b1;
      next_st.busy_cnt = EXEC_LAST;
      if (wr_b.word.rs) begin
        next_st.dr = op;
        unique case (st.tgt)
          TGT_DISP: begin
            if (wi[6]) begin
              next_st.disp[wi[5:0]] = op;
            end
          end
          TGT_GLYPH: next_st.glyph[st.ac[4:0]] = op[4:0];
          TGT_ICON:  next_st.icon[st.ac[2:0]]  = op[4:0];
          TGT_ANN:   next_st.ann[st.ac[0]]     = op[4:0];
        endcase
        next_st.ac = step(st.ac, st.dir_up);
      end else if (op[OP_DISP_BIT]) begin
        next_st.tgt = TGT_DISP;
        next_st.ac  = op[6:0];
        next_st.dr  = mem_rd(st, TGT_DISP, op[6:0]);
      end else if (op[OP_GLYPH_BIT]) begin
        next_st.tgt = TGT_GLYPH;
        next_st.ac  = {2'h0, op[4:0]};
        next_st.dr  = mem_rd(st, TGT_GLYPH, {2'h0, op[4:0]});
      end else if (op[OP_ICON_BIT]) begin
        next_st.tgt = op[OP_ANN_BIT] ? TGT_ANN : TGT_ICON;
        next_st.ac  = {4'h0, op[2:0]};
        next_st.dr  = mem_rd(st, next_st.tgt, {4'h0, op[2:0]});
      end else if (op[OP_MODE_BIT]) begin
        next_st.dir_up    = op[OP_DIR_BIT];
        next_st.two_lines = op[OP_LINES_BIT];
      end else if (op[OP_START_BIT]) begin
        if (op[2:0] <= LAST_LINE) begin
          next_st.start_line = op[2:0];
        end
      end else if (op == OP_CLEAR) begin
        next_st.disp     = {DISP_CELLS{CLEAR_CHAR}};
        next_st.ac       = 7'h00;
        next_st.tgt      = TGT_DISP;
        next_st.dir_up   = RST_DIR_UP;
        next_st.busy_cnt = CLEAR_LAST;
      end
    end

    // Pending buffered words count as busy so a poller never overruns
    next_st.busy_flag = next_st.busy | wr_a.valid | wr_b.valid;

    // Status never shows the instruction register, only flag and counter
    status  = {st.busy_flag, st.ac};
    rd_byte = register_select_line ? st.dr : status;
    next_st.bus_data_oe = mode[1] & read_write_line & enable_strobe;
    if (mode == MODE_BUS8) begin
      next_st.bus_data_out = rd_byte;
    end else begin
      next_st.bus_data_out = {low_phase ? rd_byte[3:0] : rd_byte[7:4],
                              4'h0};
    end

    // Panel scan: in two-line mode row 1 is the line after the start line, wrapping at five; otherwise it repeats the start line
    sl = (scan_row && st.two_lines) ? 3'(st.start_line + 3'h1) : st.start_line;
    if (sl > LAST_LINE) begin
      sl = 3'(sl - 3'h5);
    end
    sc = st.seg_reversed ? 4'(LAST_COL - scan_col) : scan_col;
    si = disp_idx({sl, sc});
    next_st.scan_char = (si[6] && scan_col <= LAST_COL) ?
                        st.disp[si[5:0]] : 8'h00;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st        <= '0;
      st.dir_up <= RST_DIR_UP;
      st.disp   <= {DISP_CELLS{RST_CHAR}};
    end else if (ce) begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from state

  assign bus_data_out = st.bus_data_out;
  assign bus_data_oe  = st.bus_data_oe;
  assign scan_char    = st.scan_char;
  assign seg_reversed = st.seg_reversed;
  assign two_lines    = st.two_lines;
  assign start_line   = st.start_line;
  assign busy_flag    = st.busy_flag;
endmodule : lhi_host_port
`default_nettype wire

// ===== lhi_pkg.sv
package lhi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_HZ        = 25_000_000;
  localparam int CLK_MHZ       = CLK_HZ / 1_000_000;
  localparam int EXEC_NS       = 40_000;
  localparam int EXEC_CYC      = (EXEC_NS * CLK_MHZ + 999) / 1000;
  localparam int CLEAR_NS      = 1_640_000;
  localparam int CLEAR_CYC     = (CLEAR_NS * CLK_MHZ + 999) / 1000;
  localparam int BUSY_CNT_W    = 17;

  ////////////////////////////////////////////////////////////////////////////
  // Interface mode pins {hi, lo}
  localparam logic [1:0] MODE_SER_A = 2'h0;
  localparam logic [1:0] MODE_SER_B = 2'h1;
  localparam logic [1:0] MODE_BUS4  = 2'h2;
  localparam logic [1:0] MODE_BUS8  = 2'h3;
  localparam logic [3:0] SER_LAST   = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Memory geometry
  localparam int         LINES       = 5;
  localparam int         COLS        = 12;
  localparam int         DISP_CELLS  = LINES * COLS;
  localparam int         GLYPH_WORDS = 32;
  localparam int         ICON_WORDS  = 8;
  localparam int         ANN_WORDS   = 2;
  localparam logic [2:0] LAST_LINE   = 3'h4;
  localparam logic [3:0] LAST_COL    = 4'hb;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction encodings
  localparam logic [7:0] OP_CLEAR    = 8'h01;
  localparam int         OP_DISP_BIT = 7;
  localparam int         OP_GLYPH_BIT = 6;
  localparam int         OP_ICON_BIT = 5;
  localparam int         OP_ANN_BIT  = 4;
  localparam int         OP_MODE_BIT = 4;
  localparam int         OP_DIR_BIT  = 3;
  localparam int         OP_LINES_BIT = 2;
  localparam int         OP_START_BIT = 3;
  localparam logic [7:0] CLEAR_CHAR  = 8'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic       RST_DIR_UP  = 1'b1;
  localparam logic [7:0] RST_CHAR    = 8'h00;

  typedef enum logic [1:0] {TGT_DISP, TGT_GLYPH, TGT_ICON, TGT_ANN} lhi_tgt_t;

  typedef struct packed {
    logic       rs;
    logic [7:0] data;
  } lhi_word_t;

endpackage : lhi_pkg

// ===== lhi_word_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lhi_word_if;
  import lhi_pkg::*;
  logic      valid;
  logic      ready;
  lhi_word_t word;
  modport src (output valid, output word, input ready);
  modport snk (input valid, input word, output ready);
endinterface : lhi_word_if
`default_nettype wire

// ===== lhi_buf.sv
`timescale 1ns/1ps
`default_nettype none
module lhi_buf #(
  parameter int DEPTH = 2
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic ce,
  lhi_word_if.snk   in_w,
  lhi_word_if.src   out_w
);
  import lhi_pkg::*;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("lhi_buf: DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][8:0] mem;
    logic [AW-1:0]         rd;
    logic [AW:0]           cnt;
  } lhi_buf_t;

  lhi_buf_t st;
  lhi_buf_t next_st;
  logic     push;
  logic     pop;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    push    = in_w.valid & in_w.ready & ce;
    pop     = out_w.valid & out_w.ready & ce;
    if (push) begin
      next_st.mem[AW'(st.rd + st.cnt[AW-1:0])] = in_w.word;
    end
    if (pop) begin
      next_st.rd = AW'(st.rd + 1'b1);
    end
    next_st.cnt = (AW+1)'(st.cnt + push - pop);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // Full refuses upstream, so the front end holds its word instead of losing it
  assign in_w.ready  = (st.cnt != (AW+1)'(DEPTH));
  assign out_w.valid = (st.cnt != '0);
  assign out_w.word  = st.mem[st.rd];
endmodule : lhi_buf
`default_nettype wire

// ===== lhi_front.sv
`timescale 1ns/1ps
`default_nettype none
module lhi_front (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic [1:0] mode,
  input  wire logic       rs,
  input  wire logic       rw,
  input  wire logic       en,
  input  wire logic [7:0] db_in,
  input  wire logic       ser_cs_n,
  input  wire logic       ser_clk,
  input  wire logic       ser_data,
  lhi_word_if.src         wr,
  output logic            rd_done,
  output logic            low_phase
);
  import lhi_pkg::*;

  typedef struct packed {
    logic      en_q;
    logic      sck_q;
    logic      nib;
    logic [3:0] hold;
    logic      pend;
    lhi_word_t word;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic      rd_done;
  } lhi_front_t;

  lhi_front_t st;
  lhi_front_t next_st;
  logic       fall;
  logic       rise;
  logic       free;
  logic       four;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st         = st;
    fall            = st.en_q & ~en;
    rise            = ~st.sck_q & ser_clk;
    four            = (mode == MODE_BUS4);
    free            = ~st.pend | wr.ready;
    next_st.en_q    = en;
    next_st.sck_q   = ser_clk;
    next_st.rd_done = 1'b0;
    if (wr.ready) begin
      next_st.pend = 1'b0;
    end
    if (mode[1]) begin
      next_st.cnt = '0;
      if (fall && rw) begin
        if (four && !st.nib) begin
          next_st.nib = 1'b1;
        end else begin
          next_st.nib     = 1'b0;
          next_st.rd_done = rs;
        end
      end else if (fall) begin
        if (four && !st.nib) begin
          next_st.nib  = 1'b1;
          next_st.hold = db_in[7:4];
        end else begin
          next_st.nib = 1'b0;
          if (free) begin
            next_st.pend      = 1'b1;
            next_st.word.rs   = rs;
            next_st.word.data = four ? {st.hold, db_in[7:4]} : db_in;
          end
        end
      end
    end else begin
      next_st.nib = 1'b0;
      if (ser_cs_n) begin
        next_st.cnt = '0;
      end else if (rise) begin
        next_st.sh = {st.sh[6:0], ser_data};
        if (st.cnt == SER_LAST) begin
          next_st.cnt = '0;
          if (free) begin
            next_st.pend = 1'b1;
            next_st.word = {st.sh, ser_data};
          end
        end else begin
          next_st.cnt = st.cnt + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign wr.valid  = st.pend;
  assign wr.word   = st.word;
  assign rd_done   = st.rd_done;
  assign low_phase = st.nib;
endmodule : lhi_front
`default_nettype wire

// ===== lhi_host_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module lhi_host_port_assertions #(
  parameter int EXEC_CYCLES  = 5,
  parameter int CLEAR_CYCLES = 20
) (
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       interface_select_hi,
  input wire logic       interface_select_lo,
  input wire logic       register_select_line,
  input wire logic       read_write_line,
  input wire logic       enable_strobe,
  input wire logic [7:0] bus_data_out,
  input wire logic       bus_data_oe,
  input wire logic       segment_order_strap,
  input wire logic       seg_reversed,
  input wire logic [2:0] start_line,
  input wire logic       two_lines,
  input wire logic       busy_flag
);
  // Slack covers a clear plus a few queued words
  localparam int BUSY_MAX = CLEAR_CYCLES + 4 * EXEC_CYCLES + 30;
  int busy_run;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    busy_run <= (srst || !busy_flag) ? 0 : busy_run + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_write_sets_busy: assert property ($fell(enable_strobe) && !read_write_line
    && interface_select_hi && interface_select_lo |-> ##[1:3] busy_flag)
    else $error("busy not raised after write");
  a_busy_min_span: assert property ($fell(busy_flag) |-> busy_run >= EXEC_CYCLES)
    else $error("busy shorter than execution time");
  a_busy_bounded: assert property (busy_run <= BUSY_MAX)
    else $error("busy stuck high");
  a_read_drives_bus: assert property (enable_strobe && read_write_line
    && interface_select_hi |=> bus_data_oe)
    else $error("read not driven");
  a_idle_bus_free: assert property (!enable_strobe || !read_write_line
    || !interface_select_hi |=> !bus_data_oe)
    else $error("bus driven outside read");
  a_status_busy_bit: assert property (enable_strobe && read_write_line
    && !register_select_line && interface_select_hi && interface_select_lo
    && !busy_flag && $past(busy_flag) == 1'b0 |=> !bus_data_out[7])
    else $error("status shows busy while idle");
  a_nibble_upper_only: assert property (interface_select_hi && !interface_select_lo
    && bus_data_oe |-> bus_data_out[3:0] == 4'h0)
    else $error("low nibble lines not zero");
  a_strap_follows: assert property (!$past(srst) && $stable(segment_order_strap)
    |=> seg_reversed == $past(segment_order_strap))
    else $error("segment order not following strap");
  a_start_in_range: assert property (start_line <= 3'h4)
    else $error("start line out of range");
  a_reset_clears: assert property (disable iff (1'b0) srst |=> !busy_flag
    && !bus_data_oe && !two_lines && start_line == 3'h0)
    else $error("reset did not clear state");

  cover property ($fell(busy_flag));
  cover property (bus_data_oe && !interface_select_lo);
  cover property (two_lines && start_line == 3'h4);
endmodule : lhi_host_port_assertions
`default_nettype wire

// ===== lhi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lhi_host_model
  import lhi_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] bus_data_out,
  output logic      [1:0] mode,
  output logic            rs,
  output logic            rw,
  output logic            en,
  output logic      [7:0] db,
  output logic            cs_n,
  output logic            sclk,
  output logic            sdata
);
  initial begin
    mode  = MODE_BUS8;
    rs    = 1'b0;
    rw    = 1'b1;
    en    = 1'b0;
    db    = 8'h5a;
    cs_n  = 1'b1;
    sclk  = 1'b0;
    sdata = 1'b0;
  end
  // Standby alternate and test inputs are tied off on the board

  ////////////////////////////////////////////////////////////////////////////
  task automatic set_mode(input logic [1:0] m);
    mode <= m;
    @(posedge sys_clk);
  endtask : set_mode

  // Released bus shows the inverse so a stale byte never looks valid
  task automatic pulse(input logic r, input logic w, input logic [7:0] d,
                       output logic [7:0] q);
    rs <= r;
    rw <= w;
    db <= d;
    en <= 1'b1;
    repeat (2) @(posedge sys_clk);
    q = bus_data_out;
    en <= 1'b0;
    // Data and select stand through the edge that sees the strobe low
    @(posedge sys_clk);
    db <= ~d;
    @(posedge sys_clk);
  endtask : pulse

  task automatic xfer(input logic r, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
    logic [7:0] a;
    logic [7:0] b;
    if (mode == MODE_BUS4) begin
      pulse(r, w, {d[7:4], ~d[7:4]}, a);
      pulse(r, w, {d[3:0], ~d[3:0]}, b);
      q = {a[7:4], b[7:4]};
    end else begin
      pulse(r, w, d, q);
    end
  endtask : xfer

  task automatic wait_idle();
    logic [7:0] s;
    for (int i = 0; i < 400; i++) begin
      xfer(1'b0, 1'b1, 8'h00, s);
      if (s[7] === 1'b0) return;
    end
  endtask : wait_idle

  task automatic wr(input logic r, input logic [7:0] d, input logic poll);
    logic [7:0] q;
    if (poll) wait_idle();
    xfer(r, 1'b0, d, q);
  endtask : wr

  task automatic rd(input logic r, output logic [7:0] q);
    wait_idle();
    xfer(r, 1'b1, 8'h00, q);
  endtask : rd

  // Select bit leads the frame; clock idles low between frames
  task automatic ser(input logic r, input logic [7:0] d, input int gap);
    logic [8:0] f;
    f = {r, d};
    cs_n <= 1'b0;
    for (int i = 8; i >= 0; i--) begin
      sdata <= f[i];
      repeat (2) @(posedge sys_clk);
      sclk <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sclk <= 1'b0;
    end
    repeat (2) @(posedge sys_clk);
    cs_n  <= 1'b1;
    sdata <= ~f[0];
    repeat (gap) @(posedge sys_clk);
  endtask : ser
endmodule : lhi_host_model
`default_nettype wire

// ===== lhi_host_interface_ram_access_bench.sv
`timescale 1ns/1ps
`default_nettype none
module lhi_host_interface_ram_access_bench;
  import lhi_pkg::*;
  localparam int EXEC = 5;
  localparam int CLR  = 20;
  logic sys_clk = 1'b0;
  logic srst    = 1'b1;
  logic ce      = 1'b1;
  logic strap   = 1'b0;
  logic row     = 1'b0;
  logic [3:0] col = 4'h0;
  logic [1:0] mode;
  logic rs, rw, en, cs_n, sclk, sdata, oe, rev, two, busy;
  logic [7:0] db, dout, chr, q, v;
  logic [2:0] sl;
  logic [7:0] d [3];
  logic [7:0] shadow [128];
  integer seed = 4462;
  int fail_count = 0;
  int tests_run = 0;

  always #20 sys_clk = ~sys_clk;

  lhi_host_model host (.sys_clk(sys_clk), .bus_data_out(dout), .mode(mode), .rs(rs),
    .rw(rw), .en(en), .db(db), .cs_n(cs_n), .sclk(sclk), .sdata(sdata));

  lhi_host_port #(.EXEC_CYCLES(EXEC), .CLEAR_CYCLES(CLR)) DUT (
    .sys_clk(sys_clk), .srst(srst), .ce(ce),
    .interface_select_hi(mode[1]), .interface_select_lo(mode[0]),
    .register_select_line(rs), .read_write_line(rw), .enable_strobe(en),
    .bus_data_in(db), .bus_data_out(dout), .bus_data_oe(oe),
    .serial_cs_n(cs_n), .serial_clk(sclk), .serial_data(sdata),
    .segment_order_strap(strap), .scan_row(row), .scan_col(col), .scan_char(chr),
    .seg_reversed(rev), .two_lines(two), .start_line(sl), .busy_flag(busy));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check8

  task automatic complete_run();
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  function automatic logic [7:0] disp_read(input logic [6:0] a, input logic [7:0] w);
    return (a[3:0] <= LAST_COL && a[6:4] <= LAST_LINE) ? w : 8'h00;
  endfunction : disp_read

  function automatic logic [6:0] scan_addr(input logic [2:0] s, input logic r,
                                           input logic t, input logic [3:0] c, input logic f);
    logic [2:0] ln;
    ln = (r && t) ? ((s == LAST_LINE) ? 3'h0 : s + 3'h1) : s;
    return {ln, f ? LAST_COL - c : c};
  endfunction : scan_addr

  task automatic scan(input logic r, input logic [3:0] c, input logic f, input logic [2:0] s);
    logic [6:0] a;
    row   <= r;
    col   <= c;
    strap <= f;
    repeat (3) @(posedge sys_clk);
    a = scan_addr(s, r, 1'b1, c, f);
    check8("scan_char", shadow[a], chr);
    check8("seg_reversed", {7'h0, f}, {7'h0, rev});
  endtask : scan

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    @(posedge sys_clk);
    check8("busy_after_reset", 8'h00, {7'h0, busy});
    host.rd(1'b0, q);
    check8("status_after_reset", 8'h00, q);
    // Last display line, then the hole after it
    for (int i = 0; i < 3; i++) d[i] = $random(seed);
    shadow[7'h4b] = d[1];
    host.wr(1'b0, 8'hca, 1'b1);
    for (int i = 0; i < 3; i++) host.wr(1'b1, d[i], 1'b1);
    host.rd(1'b0, q);
    check8("counter_up", 8'h4d, q);
    host.wr(1'b0, 8'hca, 1'b1);
    for (int i = 0; i < 3; i++) begin
      host.rd(1'b1, q);
      check8("display_read", disp_read(7'h4a + 7'(i), d[i]), q);
    end
    // Back-to-back writes without polling must all land
    for (int i = 0; i < 3; i++) d[i] = $random(seed);
    host.wr(1'b0, 8'hb0, 1'b1);
    for (int i = 0; i < 3; i++) host.wr(1'b1, d[i], 1'b0);
    host.wr(1'b0, 8'hb0, 1'b1);
    for (int i = 0; i < 3; i++) begin
      host.rd(1'b1, q);
      check8("burst_read", d[i], q);
    end
    // Glyph and icon stores keep five bits
    foreach (d[i]) begin
      v = $random(seed);
      host.wr(1'b0, (i == 0) ? 8'h45 : 8'h23, 1'b1);
      host.wr(1'b1, v, 1'b1);
      host.wr(1'b0, (i == 0) ? 8'h45 : 8'h23, 1'b1);
      host.rd(1'b1, q);
      check8("small_store", {3'h0, v[4:0]}, q);
    end
    // Downward counting, two lines
    host.wr(1'b0, 8'h14, 1'b1);
    host.wr(1'b0, 8'ha0, 1'b1);
    host.wr(1'b1, $random(seed), 1'b1);
    host.rd(1'b0, q);
    check8("counter_down", 8'h1f, q);
    check8("two_lines", 8'h01, {7'h0, two});
    host.wr(1'b0, 8'h1c, 1'b1);
    host.wr(1'b0, 8'h0c, 1'b1);
    host.wr(1'b0, 8'h0f, 1'b1);
    host.rd(1'b0, q);
    check8("start_line", 8'h04, {5'h0, sl});
    // Serial path writes address zero
    v = $random(seed);
    shadow[7'h00] = v;
    host.set_mode(MODE_SER_A);
    host.ser(1'b0, 8'h80, EXEC + 20);
    host.set_mode(MODE_SER_B);
    host.ser(1'b1, v, EXEC + 20);
    host.set_mode(MODE_BUS8);
    host.wr(1'b0, 8'h80, 1'b1);
    host.rd(1'b1, q);
    check8("serial_write", v, q);
    scan(1'b0, 4'hb, 1'b0, 3'h4);
    scan(1'b0, 4'h0, 1'b1, 3'h4);
    scan(1'b1, 4'hb, 1'b1, 3'h4);
    // Nibble transfers
    v = $random(seed);
    host.set_mode(MODE_BUS4);
    host.wr(1'b0, 8'h85, 1'b1);
    host.wr(1'b1, v, 1'b1);
    host.wr(1'b0, 8'h85, 1'b1);
    host.rd(1'b1, q);
    check8("nibble_read", v, q);
    host.rd(1'b0, q);
    check8("nibble_status", 8'h06, q);
    host.set_mode(MODE_BUS8);
    // Clear fills with blanks; counter then steps on from the reloaded address 4a
    host.wr(1'b0, OP_CLEAR, 1'b1);
    host.wr(1'b0, 8'hca, 1'b1);
    host.rd(1'b1, q);
    check8("clear_fill", CLEAR_CHAR, q);
    host.rd(1'b0, q);
    check8("clear_counter", 8'h4b, q);
    // Enable low freezes the scan output even onto a hole column
    ce  <= 1'b0;
    col <= 4'hf;
    repeat (3) @(posedge sys_clk);
    check8("ce_freeze", CLEAR_CHAR, chr);
    ce <= 1'b1;
    srst <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    @(posedge sys_clk);
    check8("reset_config", 8'h00, {4'h0, two, sl});
    complete_run();
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    complete_run();
  end
endmodule : lhi_host_interface_ram_access_bench

bind lhi_host_port lhi_host_port_assertions #(
  .EXEC_CYCLES(EXEC_CYCLES), .CLEAR_CYCLES(CLEAR_CYCLES)
) u_chk (
  .sys_clk(sys_clk), .srst(srst), .interface_select_hi(interface_select_hi),
  .interface_select_lo(interface_select_lo), .register_select_line(register_select_line),
  .read_write_line(read_write_line), .enable_strobe(enable_strobe),
  .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
  .segment_order_strap(segment_order_strap), .seg_reversed(seg_reversed),
  .start_line(start_line), .two_lines(two_lines), .busy_flag(busy_flag)
);
`default_nettype wire
